// [hdl/ats_seq.sv]
// Track/hold and conversion sequencer behind a two-wire serial slave port.
// Notes on behaviour
// - Internal clock mode: track starts on eighth rising clock of the address byte.
// - Internal clock mode: hold starts on falling edge of the address acknowledge pulse.
// - Internal mode: convert from internal clock, holding the serial clock low meanwhile.
// - External mode: track starts on rising edge of a read direction bit after address match.
// - External mode: hold starts on second rising clock of the first result byte.
// - External mode: conversion runs over the next ten serial clock cycles.
// - Each conversion takes ten conversion clocks, one result bit decided per clock.
// - Acquisition lasts 1.5 serial periods internally, 3 periods externally.
// - Input type 1 converts the chosen channel against ground.
// - Input type 0 converts the chosen positive/negative input pair.
// - Only in differential mode does the polarity bit select unipolar or bipolar.
// - Unipolar range is zero to reference; negative input gives an all-zero code.
// - Bipolar spans plus/minus half reference; codes two's complement.
// - Single-ended mode is always unipolar straight binary, whatever the polarity bit.
// - Last address bit gives direction: 0 write, 1 read.
// - Written byte with top bit 1 is setup, else configuration.
// - External mode uses the serial bus clock as conversion clock.
`timescale 1ns/1ps
`include "ats_regs.svh"
module ats_seq #(
  parameter logic [`ATS_ADDR_BITS-1:0] DEV_ADDR = 7'h2a, // Bus address; this value is arbitrary.
  parameter int INT_CONV_CYC = `ATS_INT_CONV_CYC
) (
  input wire logic clock_in,
  input wire logic nrst_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic comp_in,
  output logic scl_out,
  output logic scl_oe_n_out,
  output logic sda_out,
  output logic sda_oe_n_out,
  output logic th_track_out,
  output logic busy_out,
  output logic single_ended_out,
  output logic bipolar_out,
  output logic [3:0] chan_sel_out,
  output logic [`ATS_RES_BITS-1:0] dac_code_out,
  output logic [`ATS_RES_BITS-1:0] result_out
);
  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic link_rst_n;
  logic [2:0] scl_s_reg;
  logic [2:0] sda_s_reg;
  logic [3:0] frame_cnt_reg;
  logic frame_clr_reg;
  logic start_det;
  logic stop_det;
  logic [3:0] bit_cnt_reg;
  logic [3:0] bit_cnt_next;
  logic [6:0] shift_reg;
  logic addr_phase_reg;
  logic hit_reg;
  logic rd_reg;
  logic rd_go_reg;
  logic rd_byte_reg;
  logic first_rd_reg;
  logic [7:0] setup_reg;
  logic [7:0] cfg_reg;
  logic track_tgl_reg;
  logic hold_e_tgl_reg;
  logic hold_i_tgl_reg;
  logic [1:0] res_s_reg;
  logic res_seen_reg;
  logic [3:0] ext_rises_reg;
  logic [`ATS_RES_BITS-1:0] res_hold_reg;
  logic [2:0] rd_idx;
  logic [7:0] rd_word;
  logic sda_oe_n_reg;
  logic sda_low_reg;
  logic [6:0] cfg_s1_reg;
  logic [6:0] cfg_s2_reg;
  logic [2:0] trk_s_reg;
  logic [2:0] hi_s_reg;
  logic [2:0] he_s_reg;
  logic [1:0] comp_s_reg;
  logic ext_mode;
  logic track_evt;
  logic hold_evt;
  logic scl_rise;
  logic scl_fall;
  logic [7:0] div_cnt_reg;
  logic int_tick_reg;
  logic seen_low_reg;
  ats_pkg::ats_state_e state_reg;
  logic scl_oe_n_reg;
  logic scl_low_reg;
  logic track_reg;
  logic busy_reg;
  logic single_reg;
  logic bipolar_reg;
  logic [3:0] chan_reg;
  logic [`ATS_RES_BITS-1:0] result_reg;
  logic res_tgl_reg;

  ats_sar_if #(.BITS(`ATS_RES_BITS)) sar_bus ();

  // Reset release through two flip-flops; the copy feeds every other process.
  always_ff @(posedge clock_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pin synchronisers; only stages one and two are compared, stage zero feeds stage one alone.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      scl_s_reg <= 3'h7;
      sda_s_reg <= 3'h7;
      comp_s_reg <= 2'b00;
    end else begin
      scl_s_reg <= {scl_s_reg[1:0], scl_in};
      sda_s_reg <= {sda_s_reg[1:0], sda_in};
      comp_s_reg <= {comp_s_reg[0], comp_in};
    end
  end
  assign start_det = sda_s_reg[2] && !sda_s_reg[1] && scl_s_reg[2] && scl_s_reg[1];
  assign stop_det = !sda_s_reg[2] && sda_s_reg[1] && scl_s_reg[2] && scl_s_reg[1];
  assign scl_rise = scl_s_reg[1] && !scl_s_reg[2];
  assign scl_fall = !scl_s_reg[1] && scl_s_reg[2];

  // A start or stop clears the link logic for a few cycles while the clock is high.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      frame_cnt_reg <= 4'h0;
      frame_clr_reg <= 1'b0;
    end else begin
      if (start_det || stop_det) begin
        frame_cnt_reg <= `ATS_FRAME_CLR_CYC;
      end else if (frame_cnt_reg != 4'h0) begin
        frame_cnt_reg <= 4'(frame_cnt_reg - 4'h1);
      end
      frame_clr_reg <= start_det || stop_det || (frame_cnt_reg > 4'h1);
    end
  end
  assign link_rst_n = rst_n && !frame_clr_reg;

  // Pulse number within the byte: 1..8 data, 9 acknowledge.
  assign bit_cnt_next = (bit_cnt_reg == `ATS_PULSE_ACK) ? 4'h1 : 4'(bit_cnt_reg + 4'h1);

  // Link-side byte framing on the serial clock; the frame reset ends it with the frame.
  always_ff @(posedge scl_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      bit_cnt_reg <= 4'h0;
      shift_reg <= 7'h00;
      addr_phase_reg <= 1'b1;
      hit_reg <= 1'b0;
      rd_reg <= 1'b0;
      rd_go_reg <= 1'b0;
      rd_byte_reg <= 1'b0;
      first_rd_reg <= 1'b0;
    end else begin
      bit_cnt_reg <= bit_cnt_next;
      shift_reg <= {shift_reg[5:0], sda_in};
      if (addr_phase_reg && bit_cnt_next == `ATS_PULSE_DIR) begin
        hit_reg <= (shift_reg == DEV_ADDR);
        rd_reg <= sda_in;
      end
      if (bit_cnt_next == `ATS_PULSE_ACK) begin
        addr_phase_reg <= 1'b0;
        first_rd_reg <= addr_phase_reg && hit_reg && rd_reg;
        if (addr_phase_reg) begin
          rd_go_reg <= hit_reg && rd_reg;
          rd_byte_reg <= 1'b0;
        end else begin
          rd_go_reg <= rd_go_reg && !sda_in;
          rd_byte_reg <= !rd_byte_reg;
        end
      end
    end
  end

  // Setup and configuration bytes survive frames; only the device reset clears them.
  always_ff @(posedge scl_in or negedge rst_n) begin
    if (!rst_n) begin
      setup_reg <= `ATS_SETUP_RST;
      cfg_reg <= `ATS_CFG_RST;
    end else if (!addr_phase_reg && hit_reg && !rd_reg && bit_cnt_next == `ATS_PULSE_DIR) begin
      if (shift_reg[6]) begin
        setup_reg <= {shift_reg, sda_in};
      end else begin
        cfg_reg <= {shift_reg, sda_in};
      end
    end
  end

  // Track and external-hold events leave the link domain as toggles.
  always_ff @(posedge scl_in or negedge rst_n) begin
    if (!rst_n) begin
      track_tgl_reg <= 1'b0;
      hold_e_tgl_reg <= 1'b0;
    end else begin
      if (addr_phase_reg && bit_cnt_next == `ATS_PULSE_DIR && shift_reg == DEV_ADDR && sda_in) begin
        track_tgl_reg <= !track_tgl_reg;
      end
      if (first_rd_reg && bit_cnt_next == `ATS_PULSE_EXT_HOLD && setup_reg[`ATS_SETUP_EXT_BIT]) begin
        hold_e_tgl_reg <= !hold_e_tgl_reg;
      end
    end
  end

  // Internal-mode hold at the falling edge that closes the address acknowledge.
  always_ff @(negedge scl_in or negedge rst_n) begin
    if (!rst_n) begin
      hold_i_tgl_reg <= 1'b0;
    end else if (bit_cnt_reg == `ATS_PULSE_ACK && first_rd_reg && !setup_reg[`ATS_SETUP_EXT_BIT]) begin
      hold_i_tgl_reg <= !hold_i_tgl_reg;
    end
  end

  // Result word crosses by toggle; the word loads on the edge its toggle flips and is stable before the toggle is seen.
  // A new word waits while a later read byte is shifting, so no byte mixes two results.
  always_ff @(posedge scl_in or negedge rst_n) begin
    if (!rst_n) begin
      res_s_reg <= 2'h0;
      res_seen_reg <= 1'b0;
      res_hold_reg <= '0;
    end else begin
      res_s_reg <= {res_s_reg[0], res_tgl_reg};
      if (res_s_reg[1] != res_seen_reg && (!rd_go_reg || first_rd_reg)) begin
        res_seen_reg <= res_s_reg[1];
        res_hold_reg <= result_reg;
      end
    end
  end

  // Read bytes: six pad bits and the top two result bits, then the low eight bits.
  assign rd_word = rd_byte_reg ? res_hold_reg[7:0] : {`ATS_RD_PAD, res_hold_reg[9:8]};
  always_comb begin
    rd_idx = 3'h7;
    if (bit_cnt_reg != `ATS_PULSE_ACK) begin
      rd_idx = 3'(4'h7 - bit_cnt_reg);
    end
  end

  // Data line changes only while the clock is low, so it is driven from falling edges.
  always_ff @(negedge scl_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      sda_oe_n_reg <= 1'b1;
      sda_low_reg <= 1'b0;
    end else begin
      sda_low_reg <= 1'b0;
      if (bit_cnt_reg == `ATS_PULSE_DIR) begin
        sda_oe_n_reg <= !(hit_reg && (addr_phase_reg || !rd_reg));
      end else if (rd_go_reg && bit_cnt_reg != 4'h0) begin
        sda_oe_n_reg <= rd_word[rd_idx];
      end else begin
        sda_oe_n_reg <= 1'b1;
      end
    end
  end

  // Settings reach the converter domain through two flip-flops; they change only at the eighth pulse of a written byte.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      cfg_s1_reg <= 7'h10; // Matches the reset setup and configuration bytes.
      cfg_s2_reg <= 7'h10;
      trk_s_reg <= 3'h0;
      hi_s_reg <= 3'h0;
      he_s_reg <= 3'h0;
    end else begin
      cfg_s1_reg <= {setup_reg[`ATS_SETUP_EXT_BIT], setup_reg[`ATS_SETUP_POL_BIT],
                     cfg_reg[`ATS_CFG_TYPE_BIT], cfg_reg[`ATS_CFG_CH_MSB:`ATS_CFG_CH_LSB]};
      cfg_s2_reg <= cfg_s1_reg;
      trk_s_reg <= {trk_s_reg[1:0], track_tgl_reg};
      hi_s_reg <= {hi_s_reg[1:0], hold_i_tgl_reg};
      he_s_reg <= {he_s_reg[1:0], hold_e_tgl_reg};
    end
  end
  assign ext_mode = cfg_s2_reg[6];
  assign track_evt = trk_s_reg[2] != trk_s_reg[1];
  assign hold_evt = ext_mode ? (he_s_reg[2] != he_s_reg[1]) : (hi_s_reg[2] != hi_s_reg[1]);

  // Input mux and polarity; single-ended forces unipolar straight binary.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      single_reg <= 1'b1;
      bipolar_reg <= 1'b0;
      chan_reg <= 4'h0;
    end else begin
      single_reg <= cfg_s2_reg[4];
      bipolar_reg <= cfg_s2_reg[5] && !cfg_s2_reg[4];
      chan_reg <= cfg_s2_reg[3:0];
    end
  end

  // Internal conversion clock, restarted by each conversion so the first step sees a settled
  // comparator answer for the top trial bit.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= 8'h00;
      int_tick_reg <= 1'b0;
    end else if (sar_bus.start) begin
      div_cnt_reg <= 8'h00;
      int_tick_reg <= 1'b0;
    end else begin
      int_tick_reg <= (div_cnt_reg == 8'(INT_CONV_CYC - 1));
      div_cnt_reg <= (div_cnt_reg == 8'(INT_CONV_CYC - 1)) ? 8'h00 : 8'(div_cnt_reg + 8'h01);
    end
  end

  // Sequencer: track, hold and convert, then hand the result over.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ats_pkg::st_idle;
    end else begin
      unique case (state_reg)
        ats_pkg::st_idle: begin
          if (track_evt) begin
            state_reg <= ats_pkg::st_track;
          end
        end
        ats_pkg::st_track: begin
          if (hold_evt) begin
            state_reg <= ats_pkg::st_conv;
          end
        end
        ats_pkg::st_conv: begin
          if (sar_bus.done) begin
            state_reg <= ats_pkg::st_done;
          end
        end
        ats_pkg::st_done: begin
          state_reg <= ats_pkg::st_idle;
        end
      endcase
    end
  end

  // Track switch, clock stretch and busy flag follow the sequencer.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      track_reg <= 1'b0;
      scl_oe_n_reg <= 1'b1;
      busy_reg <= 1'b0;
      scl_low_reg <= 1'b0;
    end else begin
      scl_low_reg <= 1'b0;
      if (state_reg == ats_pkg::st_idle && track_evt) begin
        track_reg <= 1'b1;
      end else if (state_reg == ats_pkg::st_track && hold_evt) begin
        track_reg <= 1'b0;
      end
      if (state_reg == ats_pkg::st_track && hold_evt) begin
        busy_reg <= 1'b1;
        scl_oe_n_reg <= ext_mode;
      end else if (state_reg == ats_pkg::st_done) begin
        busy_reg <= 1'b0;
        scl_oe_n_reg <= 1'b1;
      end
    end
  end

  // In external mode only a rise after a seen fall steps, so the hold edge itself never counts.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      seen_low_reg <= 1'b0;
    end else if (state_reg != ats_pkg::st_conv) begin
      seen_low_reg <= 1'b0;
    end else if (scl_fall) begin
      seen_low_reg <= 1'b1;
    end
  end

  // Serial clock rises within an external conversion; read only by the step-count check.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ext_rises_reg <= 4'h0;
    end else if (state_reg != ats_pkg::st_conv) begin
      ext_rises_reg <= 4'h0;
    end else if (scl_rise && ext_mode) begin
      ext_rises_reg <= 4'(ext_rises_reg + 4'h1);
    end
  end

  // Conversion core; it steps on the internal tick or on serial clock rises.
  assign sar_bus.start = (state_reg == ats_pkg::st_track) && hold_evt;
  assign sar_bus.step = (state_reg == ats_pkg::st_conv) &&
                        (ext_mode ? (scl_rise && seen_low_reg) : int_tick_reg);
  assign sar_bus.comp = comp_s_reg[1];
  assign sar_bus.bipolar = bipolar_reg;
  ats_sar #(.BITS(`ATS_RES_BITS)) u_sar (
    .clk_in(clock_in),
    .rst_n_in(rst_n),
    .sar(sar_bus)
  );

  // Finished word and its toggle for the link side.
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= '0;
      res_tgl_reg <= 1'b0;
    end else if (sar_bus.done) begin
      result_reg <= sar_bus.result;
      res_tgl_reg <= !res_tgl_reg;
    end
  end

  assign scl_out = scl_low_reg;
  assign scl_oe_n_out = scl_oe_n_reg;
  assign sda_out = sda_low_reg;
  assign sda_oe_n_out = sda_oe_n_reg;
  assign th_track_out = track_reg;
  assign busy_out = busy_reg;
  assign single_ended_out = single_reg;
  assign bipolar_out = bipolar_reg;
  assign chan_sel_out = chan_reg;
  assign dac_code_out = sar_bus.trial;
  assign result_out = result_reg;

  a_track_on_event: assert property (@(posedge clock_in) disable iff (!rst_n)
    state_reg == ats_pkg::st_idle && track_evt |=> th_track_out ##1 th_track_out)
    else $error("track did not start on the track event");
  a_hold_int_stretch: assert property (@(posedge clock_in) disable iff (!rst_n)
    state_reg == ats_pkg::st_track && hold_evt && !ext_mode |=> !th_track_out && !scl_oe_n_out)
    else $error("internal hold did not stretch the clock");
  a_scl_held_conv: assert property (@(posedge clock_in) disable iff (!rst_n)
    state_reg == ats_pkg::st_conv && !ext_mode && !$changed(ext_mode) |-> !scl_oe_n_out)
    else $error("clock released during internal conversion");
  a_ext_no_stretch: assert property (@(posedge clock_in) disable iff (!rst_n)
    state_reg == ats_pkg::st_conv && ext_mode |-> scl_oe_n_out)
    else $error("clock stretched in external mode");
  a_scl_release: assert property (@(posedge clock_in) disable iff (!rst_n)
    state_reg == ats_pkg::st_done |=> scl_oe_n_out && !busy_out && res_tgl_reg != $past(res_tgl_reg, 2))
    else $error("clock or result not released after conversion");
  a_single_unipolar: assert property (@(posedge clock_in) disable iff (!rst_n)
    single_ended_out |-> !bipolar_out)
    else $error("single-ended input converted as bipolar");
  a_ext_step_clock: assert property (@(posedge clock_in) disable iff (!rst_n)
    sar_bus.done && ext_mode |-> ext_rises_reg == 4'ha)
    else $error("external conversion did not take ten serial clock rises");
  a_hold_ends_track: assert property (@(posedge clock_in) disable iff (!rst_n)
    sar_bus.start |=> !th_track_out && busy_out)
    else $error("hold did not begin with conversion start");
  c_int_conv: cover property (@(posedge clock_in) disable iff (!rst_n)
    state_reg == ats_pkg::st_done && !ext_mode);
  c_ext_conv: cover property (@(posedge clock_in) disable iff (!rst_n)
    state_reg == ats_pkg::st_done && ext_mode);
  c_bipolar: cover property (@(posedge clock_in) disable iff (!rst_n)
    sar_bus.done && bipolar_reg);
endmodule

// [inc/ats_regs.svh]
// Constants for the track/hold and conversion sequencer: bit positions, reset values, timing.
`ifndef ATS_REGS_SVH
`define ATS_REGS_SVH
`define ATS_CLK_PERIOD_NS 4
`define ATS_INT_CONV_NS 120
`define ATS_INT_CONV_CYC (`ATS_INT_CONV_NS / `ATS_CLK_PERIOD_NS)
`define ATS_FRAME_CLR_NS 16
`define ATS_FRAME_CLR_CYC 4'((`ATS_FRAME_CLR_NS + `ATS_CLK_PERIOD_NS - 1) / `ATS_CLK_PERIOD_NS)
`define ATS_RES_BITS 10
`define ATS_ADDR_BITS 7
`define ATS_PULSE_DIR 4'h8
`define ATS_PULSE_ACK 4'h9
`define ATS_PULSE_EXT_HOLD 4'h2
`define ATS_SETUP_FLAG_BIT 7
`define ATS_SETUP_EXT_BIT 3
`define ATS_SETUP_POL_BIT 2
`define ATS_CFG_CH_MSB 4
`define ATS_CFG_CH_LSB 1
`define ATS_CFG_TYPE_BIT 0
`define ATS_SETUP_RST 8'h80
`define ATS_CFG_RST 8'h01
`define ATS_RD_PAD 6'h00
`endif

// [inc/ats_pkg.sv]
// Types shared by the sequencer modules.
package ats_pkg;
  typedef enum logic [3:0] {
    st_idle = 4'h1,
    st_track = 4'h2,
    st_conv = 4'h4,
    st_done = 4'h8
  } ats_state_e;
endpackage

// [inc/ats_sar_if.sv]
// Signals between the sequencer and its successive-approximation core.
`timescale 1ns/1ps
interface ats_sar_if #(parameter int BITS = 10);
  logic start;
  logic step;
  logic comp;
  logic bipolar;
  logic busy;
  logic done;
  logic [BITS-1:0] trial;
  logic [BITS-1:0] result;
  modport core (input start, input step, input comp, input bipolar,
                output busy, output done, output trial, output result);
  modport ctrl (output start, output step, output comp, output bipolar,
                input busy, input done, input trial, input result);
endinterface

// [hdl/ats_sar.sv]
// Successive-approximation core that decides one result bit per conversion step.
`timescale 1ns/1ps
module ats_sar #(
  parameter int BITS = 10
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  ats_sar_if.core sar
);
  logic [BITS-1:0] trial_reg;
  logic [BITS-1:0] ptr_reg;
  logic [BITS-1:0] kept;
  logic [BITS-1:0] result_reg;
  logic busy_reg;
  logic done_reg;
  logic [4:0] steps_reg;

  // A low comparator answer drops the bit under trial; an input below zero so ends at zero.
  assign kept = sar.comp ? trial_reg : (trial_reg & ~ptr_reg);

  // Trial word and bit pointer walk from the most significant bit downward.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      trial_reg <= '0;
      ptr_reg <= '0;
      busy_reg <= 1'b0;
    end else if (sar.start) begin
      trial_reg <= {1'b1, {(BITS-1){1'b0}}};
      ptr_reg <= {1'b1, {(BITS-1){1'b0}}};
      busy_reg <= 1'b1;
    end else if (sar.step && busy_reg) begin
      trial_reg <= kept | (ptr_reg >> 1);
      ptr_reg <= ptr_reg >> 1;
      busy_reg <= !ptr_reg[0];
    end
  end

  // Bipolar results flip the top bit, turning offset binary into two's complement.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      result_reg <= '0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= sar.step && busy_reg && ptr_reg[0];
      if (sar.step && busy_reg && ptr_reg[0]) begin
        result_reg <= sar.bipolar ? {~kept[BITS-1], kept[BITS-2:0]} : kept;
      end
    end
  end

  // Step counter read only by the checks below.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      steps_reg <= 5'h00;
    end else if (sar.start) begin
      steps_reg <= 5'h00;
    end else if (sar.step && busy_reg) begin
      steps_reg <= 5'(steps_reg + 5'h01);
    end
  end

  assign sar.trial = trial_reg;
  assign sar.result = result_reg;
  assign sar.busy = busy_reg;
  assign sar.done = done_reg;

  a_sar_ten_steps: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    $rose(done_reg) |-> steps_reg == 5'(BITS))
    else $error("conversion ended after a wrong number of steps");
  a_sar_msb_first: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sar.start |=> trial_reg == {1'b1, {(BITS-1){1'b0}}} && busy_reg)
    else $error("conversion did not begin at the top bit");
  a_uni_zero_code: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    sar.step && busy_reg && !sar.comp |=> (trial_reg & $past(ptr_reg)) == '0)
    else $error("bit under trial kept although the comparator was low");
  c_sar_done: cover property (@(posedge clk_in) disable iff (!rst_n_in) $rose(done_reg));
endmodule

// [verification/ats_master.sv]
// Two-wire bus master model that drives the sequencer's serial port.
`timescale 1ns/1ps
module ats_master #(
  parameter int HALF = 6
) (
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic sda_out
);
  logic stall;
  // Idle bus: both lines released to the pull-ups, clock standing still.
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    stall = 1'b0;
  end
  // Shifts n bits MSB first; data moves 2 ns after the fall so it never looks like a START.
  task automatic xfer(input logic [7:0] d, input int n, output logic [7:0] q);
    q = 8'h00;
    for (int i = 0; i < n; i++) begin
      #2 sda_out = d[7-i];
      #(HALF-2) scl_out = 1'b1;
      // The slave may stretch the low phase, so wait for the wire, but not forever.
      for (int k = 0; k < 500 && scl_in !== 1'b1; k++) #4;
      if (scl_in !== 1'b1) stall = 1'b1;
      #HALF q = {q[6:0], sda_in};
      scl_out = 1'b0;
    end
  endtask
  // START: data falls while the clock is high.
  task automatic start();
    #2 sda_out = 1'b1;
    #HALF scl_out = 1'b1;
    #40 sda_out = 1'b0;
    #40 scl_out = 1'b0;
  endtask
  // STOP: data rises while the clock is high.
  task automatic stop();
    #2 sda_out = 1'b0;
    #HALF scl_out = 1'b1;
    #40 sda_out = 1'b1;
    #40;
  endtask
endmodule

// [verification/test_ats_seq.sv]
// Self-checking bench for the track/hold and conversion sequencer.
`timescale 1ns/1ps
module test_ats_seq;
  localparam logic [6:0] ADDR = 7'h2a; // Bus address; this value is arbitrary.
  logic clock_in = 1'b0;
  logic nrst_in = 1'b0;
  logic comp_in, m_scl, m_sda, scl_w, sda_w, scl_out, scl_oe_n_out, sda_out, sda_oe_n_out;
  logic th_track_out, busy_out, single_ended_out, bipolar_out;
  logic [3:0] chan_sel_out;
  logic [9:0] dac_code_out, result_out;
  int mismatches = 0;
  int n_compared = 0;
  int tgt = 0;
  bit neg = 1'b0;
  int hist[$];
  logic [7:0] q;
  // Open-drain lines: any party pulling low wins over the pull-up.
  assign scl_w = m_scl & (scl_oe_n_out | scl_out);
  assign sda_w = m_sda & (sda_oe_n_out | sda_out);
  // Comparator model: high while the held input is at or above the DAC trial.
  assign comp_in = !neg && (tgt >= int'(dac_code_out));
  ats_seq #(.DEV_ADDR(ADDR), .INT_CONV_CYC(4)) ats_seq_inst (
    .clock_in(clock_in), .nrst_in(nrst_in), .scl_in(scl_w), .sda_in(sda_w),
    .comp_in(comp_in), .scl_out(scl_out), .scl_oe_n_out(scl_oe_n_out), .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out), .th_track_out(th_track_out), .busy_out(busy_out),
    .single_ended_out(single_ended_out), .bipolar_out(bipolar_out),
    .chan_sel_out(chan_sel_out), .dac_code_out(dac_code_out), .result_out(result_out));
  ats_master ats_master_inst (.scl_in(scl_w), .sda_in(sda_w), .scl_out(m_scl), .sda_out(m_sda));
  // Core clock, 4 ns period.
  initial begin
    forever #2 clock_in = ~clock_in;
  end
  // Counts every comparison and reports each mismatch at once.
  task automatic chk(input string nm, input logic [9:0] got, input logic [9:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Reference code: clamp to zero below range, MSB flipped for two's complement.
  function automatic int expect_code(int t, bit n, bit bip);
    if (n) return bip ? 32'h200 : 0;
    return bip ? (t ^ 32'h200) : t;
  endfunction
  // Ends a frame; a clock held low too long by the slave ends the run.
  task automatic end_frame();
    ats_master_inst.stop();
    #40;
    if (ats_master_inst.stall) begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] b0, b1, input logic acked);
    logic [7:0] ack;
    logic [7:0] bs [2];
    bs = '{b0, b1};
    ats_master_inst.start();
    ats_master_inst.xfer({a, 1'b0}, 8, q);
    ats_master_inst.xfer(8'hff, 1, ack);
    chk("addr ack", ack[0], !acked);
    for (int i = 0; i < 2; i++) begin
      ats_master_inst.xfer(bs[i], 8, q);
      ats_master_inst.xfer(8'hff, 1, ack);
      chk("data ack", ack[0], !acked);
    end
    end_frame();
  endtask
  task automatic rd(input bit ext, output logic [9:0] r);
    logic [7:0] a, b, c;
    ats_master_inst.start();
    ats_master_inst.xfer({ADDR, 1'b1}, 8, q);
    #20 chk("track", th_track_out, 1'b1);
    ats_master_inst.xfer(8'hff, 1, a);
    chk("read ack", a[0], 1'b0);
    #20;
    if (!ext) begin
      chk("hold", th_track_out, 1'b0);
      chk("stretch", {busy_out, scl_oe_n_out}, 2'b10);
    end
    // In external mode the hold falls exactly on the second data pulse.
    for (int i = 0; i < 2; i++) begin
      ats_master_inst.xfer(8'hff, 1, a);
      #20;
      if (ext) chk("ext hold", {th_track_out, busy_out}, (i == 0) ? 2'b10 : 2'b01);
    end
    ats_master_inst.xfer(8'hff, 6, c);
    ats_master_inst.xfer(8'h00, 1, q);
    ats_master_inst.xfer(8'hff, 8, b);
    ats_master_inst.xfer(8'hff, 1, q);
    end_frame();
    chk("pad", c[5:2], 4'h0);
    r = {c[1:0], b};
  endtask
  initial begin
    logic [9:0] r;
    bit ty, pol;
    logic [3:0] ch;
    void'($urandom(61861));
    repeat (5) @(negedge clock_in);
    nrst_in = 1'b1;
    repeat (10) @(negedge clock_in);
    chk("reset", {single_ended_out, chan_sel_out, bipolar_out, th_track_out, busy_out,
                  scl_oe_n_out, sda_oe_n_out}, 10'h203);
    // Serial edges the master drives from here on fall between core clock edges, never on them.
    #1;
    // A foreign address must be ignored along with its data bytes.
    wr(ADDR ^ 7'h01, 8'h8c, 8'h1e, 1'b0);
    chk("refused", {single_ended_out, chan_sel_out, bipolar_out}, 6'h20);
    // Every input type and polarity, both byte orders, clamp cases last.
    for (int i = 0; i < 7; i++) begin
      ty = i[0];
      pol = i[1];
      ch = 4'($urandom);
      tgt = $urandom % 1024;
      neg = i >= 4;
      if (i[0]) wr(ADDR, {5'h10, pol, 2'h0}, {3'h0, ch, ty}, 1'b1);
      else wr(ADDR, {3'h0, ch, ty}, {5'h10, pol, 2'h0}, 1'b1);
      chk("mode", {single_ended_out, chan_sel_out, bipolar_out}, {ty, ch, pol & !ty});
      hist.push_back(expect_code(tgt, neg, pol & !ty));
      rd(1'b0, r);
      chk("int result", r, 10'(hist[$]));
    end
    // External clock mode: each read shifts out the previous result.
    wr(ADDR, 8'h88, 8'h03, 1'b1);
    neg = 1'b0;
    for (int j = 0; j < 2; j++) begin
      tgt = $urandom % 1024;
      rd(1'b1, r);
      chk("ext read", r, 10'(hist[$]));
      hist.push_back(tgt);
      chk("ext conv", result_out, 10'(hist[$]));
    end
    test_done();
  end
endmodule
